// >>> common/lsul_consts.vh
// Constants for the LIN synchronisation and UART link block.
`ifndef LSUL_CONSTS_VH
`define LSUL_CONSTS_VH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define LSUL_A_TX       12'h000
`define LSUL_A_RX       12'h004
`define LSUL_A_DIVLO    12'h008
`define LSUL_A_DIVHI    12'h00C
`define LSUL_A_FRAC     12'h010
`define LSUL_A_LCR      12'h014
`define LSUL_A_LSR      12'h018
`define LSUL_A_SYNCT    12'h01C
`define LSUL_A_BRKT     12'h020
`define LSUL_A_CTRLA    12'h024
`define LSUL_A_EDGE     12'h028
`define LSUL_A_STAT     12'h02C
`define LSUL_A_MASK     12'h030
`define LSUL_A_P2DAT    12'h034
`define LSUL_A_P2CFG    12'h038
`define LSUL_A_P1CFG    12'h03C
`define LSUL_A_HV_STATUS    12'h040
`define LSUL_A_HVCFG    12'h044
// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define LSUL_CA_EN      0
`define LSUL_CA_GATE    8
`define LSUL_ST_BRK     0
`define LSUL_ST_STOP    1
`define LSUL_ST_BERR    4
`define LSUL_ST_SC      2
`define LSUL_P2_LINRD   4
`define LSUL_P2_LINDRV  5
`define LSUL_P2_GPIO    20
`define LSUL_P1_UEXT    0
`define LSUL_HV_SCDIS   2
`define LSUL_HV_REEN    3
`define LSUL_CMP_RST    12'h047
`define LSUL_EDGE_RST   8'h32
`define LSUL_CTRLA_RST  9'h000
`define LSUL_DIV_RST    8'h01
`define LSUL_LCR_RST    8'h03
// ---------------------------------------------------------------
// Clock rates (kHz) and derived enable divisors at 125 MHz
// ---------------------------------------------------------------
`define LSUL_PCLK_KHZ   125000
`define LSUL_SYNC_KHZ   5000
`define LSUL_BRK_KHZ    131
`define LSUL_SYNC_DIV   (`LSUL_PCLK_KHZ / `LSUL_SYNC_KHZ)
`define LSUL_BRK_DIV    (`LSUL_PCLK_KHZ / `LSUL_BRK_KHZ)
`define LSUL_OVS        16
`endif

// >>> sim/lsul_asserts.sv
// Port-level checker for the LIN synchronisation and UART link block.
`timescale 1ns/100ps
`include "lsul_consts.vh"
module lsul_asserts (
  input wire pclk, // Core clock.
  input wire presetn, // Reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [11:0] paddr, // APB address.
  input wire [31:0] pwdata, // APB write data.
  input wire [31:0] prdata, // APB read data.
  input wire pready, // APB ready.
  input wire pslverr, // APB error.
  input wire lin_rx_pin, // LIN receive level.
  input wire lin_tx_pin, // LIN drive level.
  input wire ext_rxd_pin, // External receive.
  input wire ext_txd_pin, // External transmit.
  input wire lin_short_pin, // Short detector.
  input wire lin_drv_en, // Driver enable.
  input wire irq // Interrupt.
);
  // ---------------------------------------------------------------
  // Shadow of the pin-routing controls
  // ---------------------------------------------------------------
  logic gpio_r, dat_r, ext_r;
  wire wr_fire = psel && penable && pready && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_r <= 1'b0;
      dat_r <= 1'b0;
      ext_r <= 1'b0;
    end else if (wr_fire) begin
      if (paddr == `LSUL_A_P2CFG) gpio_r <= pwdata[`LSUL_P2_GPIO];
      if (paddr == `LSUL_A_P2DAT) dat_r <= pwdata[`LSUL_P2_LINDRV];
      if (paddr == `LSUL_A_P1CFG) ext_r <= pwdata[`LSUL_P1_UEXT];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_pready_latency: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata set on write");
  a_unmapped_err: assert property ($rose(penable) && psel && paddr > `LSUL_A_HVCFG |=> pslverr)
    else $error("unmapped access not refused");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && lin_tx_pin && ext_txd_pin)
    else $error("outputs not idle after reset");
  a_gpio_drive: assert property (gpio_r && $past(gpio_r) && $stable(dat_r) |-> lin_tx_pin == dat_r)
    else $error("LIN pin does not follow port data");
  a_ext_idle: assert property (!ext_r && $stable(ext_r) |-> ext_txd_pin)
    else $error("external transmit active while not routed");
  a_lin_idle_ext: assert property (ext_r && $stable(ext_r) && !gpio_r |-> lin_tx_pin)
    else $error("LIN pin active while routed out");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_gpio_low: cover property (gpio_r && !lin_tx_pin);
endmodule // lsul_asserts
bind lsul_link lsul_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .lin_rx_pin, .lin_tx_pin, .ext_rxd_pin, .ext_txd_pin,
  .lin_short_pin, .lin_drv_en, .irq);

// >>> sim/lsul_lin_master.sv
// Behavioural LIN master node that sends break, sync and bytes and receives bytes.
`timescale 1ns/100ps
module lsul_lin_master (
  input wire pclk, // Clock used to time bits.
  input wire tx_line, // Line the slave transmits on.
  output logic line // Master drive, high when released.
);
  initial line = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic send_break(input int n);
    line <= 1'b0;
    hold(n);
    line <= 1'b1;
    hold(100);
  endtask
  // Plain start, eight data bits LSB first, then the line driven high for two bit times as stop and idle.
  task automatic send_byte(input logic [7:0] b, input int bit_c);
    int i;
    line <= 1'b0;
    hold(bit_c);
    for (i = 0; i < 8; i++) begin
      line <= b[i];
      hold(bit_c);
    end
    line <= 1'b1;
    hold(2 * bit_c);
  endtask
  task automatic recv_byte(input int bit_c, output logic [7:0] b, output bit ok);
    int n;
    int i;
    n = 0;
    ok = 0;
    b = 8'h00;
    while (tx_line !== 1'b0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n < 4000) begin
      hold(bit_c + bit_c / 2);
      for (i = 0; i < 8; i++) begin
        b[i] = tx_line;
        hold(bit_c);
      end
      ok = (tx_line === 1'b1);
    end
  endtask
endmodule // lsul_lin_master

// >>> sim/tb.sv
// Self-checking testbench for the LIN synchronisation and UART link block.
`timescale 1ns/100ps
`include "lsul_consts.vh"
module tb;
  localparam int BITC = 48;
  logic pclk, presetn, psel, penable, pwrite, lin_short_pin, use_ext, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0] rb;
  logic err_seen;
  wire [31:0] prdata;
  wire pready, pslverr, lin_tx_pin, ext_txd_pin, lin_drv_en, irq, mline;
  wire lin_lvl = lin_drv_en ? lin_tx_pin : 1'b1;
  wire bus = mline & lin_lvl;
  int errors, checks_done;
  logic [11:0] ra [8] = '{`LSUL_A_EDGE, `LSUL_A_DIVLO, `LSUL_A_LCR, `LSUL_A_CTRLA,
    `LSUL_A_STAT, `LSUL_A_DIVHI, `LSUL_A_BRKT, `LSUL_A_HV_STATUS};
  logic [31:0] rv [8] = '{32'h32, 32'h01, 32'h03, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  lsul_link dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .lin_rx_pin(use_ext ? lin_lvl : bus), .lin_tx_pin,
    .ext_rxd_pin(use_ext ? mline : 1'b1), .ext_txd_pin, .lin_short_pin, .lin_drv_en, .irq);
  lsul_lin_master lm (.pclk, .tx_line(use_ext ? ext_txd_pin : bus), .line(mline));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // Bus access and comparison tasks
  // ---------------------------------------------------------------
  task end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("[FAIL] pready expected 1 seen 0");
      errors++;
      end_sim;
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    tick(100000);
    $display("[FAIL] run time expected done seen running");
    errors++;
    end_sim;
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, presetn, lin_short_pin, use_ext} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    checks_done = 0;
    tick(20);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk("reset value", ra[i], 32'hFFFFFFFF, rv[i]);
    apb(12'hFFC, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    wr(`LSUL_A_EDGE, 32'h62);
    rdchk("edge ctrl", `LSUL_A_EDGE, 32'hFF, 32'h62);
    wr(`LSUL_A_BRKT, 32'h003);
    wr(`LSUL_A_CTRLA, 32'h101);
    lm.send_break(6 * `LSUL_BRK_DIV);
    rdchk("break status", `LSUL_A_STAT, 32'h13, 32'h01);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`LSUL_A_MASK, 32'h13);
    tick(2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    lm.send_byte(8'h55, BITC);
    tick(10);
    rdchk("stop status", `LSUL_A_STAT, 32'h13, 32'h03);
    rdchk("rx while gated", `LSUL_A_LSR, 32'h01, 32'h0);
    apb(`LSUL_A_SYNCT, 1'b0, 32'h0);
    checks_done++;
    if (rd < 14 || rd > 16) begin
      $display("[FAIL] sync timer expected 15 seen %0d", rd);
      errors++;
    end
    // Divisor from eight measured bit times, rounded to the nearest whole step.
    wr(`LSUL_A_DIVLO, (rd * `LSUL_SYNC_DIV + 64) / (8 * `LSUL_OVS));
    wr(`LSUL_A_STAT, 32'h13);
    rdchk("status cleared", `LSUL_A_STAT, 32'h13, 32'h0);
    tick(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(`LSUL_A_DIVHI, 32'h0);
    wr(`LSUL_A_FRAC, 32'h0);
    wr(`LSUL_A_LCR, 32'h03);
    wr(`LSUL_A_CTRLA, 32'h001);
    lm.send_byte(8'hA5, BITC);
    rdchk("rx full", `LSUL_A_LSR, 32'h0B, 32'h01);
    rdchk("rx byte", `LSUL_A_RX, 32'hFF, 32'hA5);
    rdchk("rx read clears", `LSUL_A_LSR, 32'h01, 32'h0);
    wr(`LSUL_A_TX, 32'h3C);
    lm.recv_byte(BITC, rb, ok);
    chk("tx byte", 32'h3C, {24'h0, rb});
    chk("tx stop", 32'h1, {31'h0, ok});
    tick(2 * BITC);
    rdchk("tx idle", `LSUL_A_LSR, 32'h60, 32'h60);
    wr(`LSUL_A_P1CFG, 32'h1);
    use_ext <= 1'b1;
    wr(`LSUL_A_TX, 32'h5A);
    lm.recv_byte(BITC, rb, ok);
    chk("ext tx byte", 32'h5A, {24'h0, rb});
    lm.send_byte(8'h96, BITC);
    rdchk("ext rx byte", `LSUL_A_RX, 32'hFF, 32'h96);
    wr(`LSUL_A_P1CFG, 32'h0);
    use_ext <= 1'b0;
    wr(`LSUL_A_P2CFG, 32'h0010_0000);
    for (int v = 0; v < 2; v++) begin
      wr(`LSUL_A_P2DAT, v << `LSUL_P2_LINDRV);
      tick(8);
      chk("lin drive", v, {31'h0, lin_tx_pin});
      rdchk("lin readback", `LSUL_A_P2DAT, 32'h10, v << `LSUL_P2_LINRD);
    end
    wr(`LSUL_A_P2CFG, 32'h0);
    lin_short_pin <= 1'b1;
    tick(8);
    lin_short_pin <= 1'b0;
    tick(8);
    rdchk("short flag", `LSUL_A_HV_STATUS, 32'h04, 32'h04);
    rdchk("short sticky", `LSUL_A_HV_STATUS, 32'h04, 32'h04);
    chk("driver off", 32'h0, {31'h0, lin_drv_en});
    wr(`LSUL_A_HVCFG, 32'h08);
    rdchk("short cleared", `LSUL_A_HV_STATUS, 32'h04, 32'h0);
    chk("driver on", 32'h1, {31'h0, lin_drv_en});
    wr(`LSUL_A_HVCFG, 32'h04);
    lin_short_pin <= 1'b1;
    tick(8);
    rdchk("short ignored", `LSUL_A_HV_STATUS, 32'h04, 32'h0);
    lin_short_pin <= 1'b0;
    end_sim;
  end
endmodule // tb

// >>> src/lsul_link.v
// LIN slave link: break and sync timing, UART registers, pin diagnostics, APB.
// Behaviour
// RQ1: UART traffic only after break and sync.
// RQ2: Software derives baud divisors from sync timer.
// RQ3: Configured UART uses plain character framing.
// RQ4: Bytes via transmit/receive registers, status checked.
// RQ5: UART lines may route to external pins.
// RQ6: Break timer starts on first falling edge.
// RQ7: Break interrupt when timer passes compare.
// RQ8: Sync timer starts at start edge, counts edges.
// RQ9: Stop edge reached stops timer, interrupts.
// RQ10: Software ungates receive only after bus high.
// RQ11: LIN pin level readable in port data.
// RQ12: Port bit drives LIN pin in GPIO mode.
// RQ13: Short circuit sets status bit two.
// RQ14: Short flag cleared only by driver re-enable.
// RQ15: Short protection can be disabled.
// RQ16: Sync timer ticks at 5 MHz.
// RQ17: Break timer overflow before rise is error.
// RQ18: Edge counts: stop high nibble, start low.
// RQ19: Break compare resets to 0x47.
`timescale 1ns/100ps
`include "lsul_consts.vh"
module lsul_link (
  input wire pclk, // Core clock, 125 MHz.
  input wire presetn, // Asynchronous reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [11:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output reg pready, // APB ready.
  output reg pslverr, // APB error on unmapped address.
  input wire lin_rx_pin, // LIN transceiver receive level.
  output reg lin_tx_pin, // LIN transceiver drive level.
  input wire ext_rxd_pin, // External receive pin.
  output reg ext_txd_pin, // External transmit pin.
  input wire lin_short_pin, // Short circuit detector.
  output reg lin_drv_en, // LIN driver enable.
  output reg irq // Level interrupt.
);
  // ---------------------------------------------------------------
  // Pin synchronisers: change taken when stages two and three agree
  // ---------------------------------------------------------------
  reg [2:0] lin_s_r;
  reg [2:0] ext_s_r;
  reg [2:0] sc_s_r;
  reg lin_r;
  reg ext_r;
  reg sc_r;
  reg lin_prev_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_s_r <= 3'h7;
      ext_s_r <= 3'h7;
      sc_s_r <= 3'h0;
      lin_r <= 1'b1;
      ext_r <= 1'b1;
      sc_r <= 1'b0;
      lin_prev_r <= 1'b1;
    end else begin
      lin_s_r <= {lin_s_r[1:0], lin_rx_pin};
      ext_s_r <= {ext_s_r[1:0], ext_rxd_pin};
      sc_s_r <= {sc_s_r[1:0], lin_short_pin};
      if (lin_s_r[1] == lin_s_r[2]) lin_r <= lin_s_r[2];
      if (ext_s_r[1] == ext_s_r[2]) ext_r <= ext_s_r[2];
      if (sc_s_r[1] == sc_s_r[2]) sc_r <= sc_s_r[2];
      lin_prev_r <= lin_r;
    end
  end
  wire lin_fall = lin_prev_r && !lin_r;
  wire lin_rise = !lin_prev_r && lin_r;
  // ---------------------------------------------------------------
  // Rate enables: 5 MHz sync tick and 131 kHz break tick
  // ---------------------------------------------------------------
  reg [15:0] sdiv_r;
  reg [15:0] bdiv_r;
  reg sync_tick_r;
  reg brk_tick_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdiv_r <= 16'h0000;
      bdiv_r <= 16'h0000;
      sync_tick_r <= 1'b0;
      brk_tick_r <= 1'b0;
    end else begin
      sync_tick_r <= (sdiv_r == `LSUL_SYNC_DIV - 1); // RQ16
      brk_tick_r <= (bdiv_r == `LSUL_BRK_DIV - 1);
      sdiv_r <= (sdiv_r == `LSUL_SYNC_DIV - 1) ? 16'h0000 : sdiv_r + 16'h0001;
      bdiv_r <= (bdiv_r == `LSUL_BRK_DIV - 1) ? 16'h0000 : bdiv_r + 16'h0001;
    end
  end
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [7:0] div_lo_r, div_hi_r, lcr_r, edge_r, mask_r, stat_r;
  reg [15:0] frac_r;
  reg [8:0] ctrla_r;
  reg [11:0] cmp_r;
  reg [31:0] p2cfg_r;
  reg [7:0] p2dat_r;
  reg [7:0] p1cfg_r;
  reg [7:0] hvcfg_r;
  reg sc_flag_r;
  reg [7:0] tx_byte_r;
  reg tx_load_r;
  reg [7:0] rx_byte_r;
  reg rx_full_r, rx_oe_r, rx_fe_r;
  wire acc = psel && penable;
  // Writes and read side effects wait for the edge that completes the transfer.
  wire wr = acc && pwrite && pready;
  wire rd = acc && !pwrite && pready;
  wire [7:0] wst = pwdata[7:0];
  // ---------------------------------------------------------------
  // Break and sync timing engine
  // ---------------------------------------------------------------
  reg [11:0] brk_t_r;
  reg [15:0] sync_t_r;
  reg [3:0] edges_r;
  reg brk_run_r, brk_ok_r, sync_run_r, hdr_done_r;
  wire en = ctrla_r[`LSUL_CA_EN];
  wire brk_hit = brk_run_r && !brk_ok_r && (brk_t_r > cmp_r);
  wire brk_ovf = brk_run_r && brk_tick_r && (brk_t_r == 12'hFFF);
  wire [3:0] edge_nx = edges_r + 4'h1;
  wire stop_hit = lin_fall && brk_ok_r && sync_run_r && (edge_nx == edge_r[7:4]); // RQ18
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_t_r <= 12'h000;
      sync_t_r <= 16'h0000;
      edges_r <= 4'h0;
      brk_run_r <= 1'b0;
      brk_ok_r <= 1'b0;
      sync_run_r <= 1'b0;
      hdr_done_r <= 1'b0;
    end else if (!en) begin
      brk_run_r <= 1'b0;
      brk_ok_r <= 1'b0;
      sync_run_r <= 1'b0;
      edges_r <= 4'h0;
      hdr_done_r <= 1'b0;
    end else begin
      if (rd && paddr == `LSUL_A_BRKT) brk_t_r <= 12'h000;
      else if (brk_run_r && brk_tick_r && !brk_ovf) brk_t_r <= brk_t_r + 12'h001;
      if (brk_hit) brk_ok_r <= 1'b1;
      if (brk_ovf) brk_run_r <= 1'b0; // RQ17
      if (brk_run_r && brk_ok_r && lin_rise) brk_run_r <= 1'b0;
      if (sync_run_r && sync_tick_r && edges_r >= edge_r[3:0]) begin
        sync_t_r <= sync_t_r + 16'h0001; // RQ16
      end
      if (lin_fall && !hdr_done_r) begin
        if (edges_r == 4'h0) begin
          brk_run_r <= 1'b1; // RQ6
          brk_t_r <= 12'h000;
          edges_r <= 4'h1;
          sync_t_r <= 16'h0000;
        end else if (brk_ok_r) begin
          edges_r <= edge_nx;
          if (edge_nx == edge_r[3:0]) sync_run_r <= 1'b1; // RQ8
          if (stop_hit) begin
            sync_run_r <= 1'b0; // RQ9
            hdr_done_r <= 1'b1; // RQ1
          end
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // UART and routing
  // ---------------------------------------------------------------
  wire ext_sel = p1cfg_r[`LSUL_P1_UEXT];
  // With the LIN path selected, the receive line idles high while gated so no false starts reach the UART.
  wire urxd = ext_sel ? ext_r : (ctrla_r[`LSUL_CA_GATE] ? 1'b1 : lin_r); // RQ5
  wire utxd, ubusy, udone, uferr;
  wire [7:0] udata;
  lsul_uart u_uart (
    .pclk(pclk),
    .presetn(presetn),
    .div({div_hi_r, div_lo_r}),
    .frac(frac_r),
    .lcr(lcr_r),
    .tx_data(tx_byte_r),
    .tx_load(tx_load_r),
    .rxd(urxd),
    .txd(utxd),
    .tx_busy(ubusy),
    .rx_data(udata),
    .rx_done(udone),
    .rx_ferr(uferr)
  ); // RQ3
  wire gpio_mode = p2cfg_r[`LSUL_P2_GPIO];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_tx_pin <= 1'b1;
      ext_txd_pin <= 1'b1;
      lin_drv_en <= 1'b1;
      irq <= 1'b0;
    end else begin
      lin_tx_pin <= gpio_mode ? p2dat_r[`LSUL_P2_LINDRV] : (ext_sel ? 1'b1 : utxd); // RQ12
      ext_txd_pin <= ext_sel ? utxd : 1'b1;
      lin_drv_en <= !sc_flag_r || hvcfg_r[`LSUL_HV_SCDIS];
      irq <= |(stat_r & mask_r);
    end
  end
  // ---------------------------------------------------------------
  // APB register writes and event flags (set wins over clear)
  // ---------------------------------------------------------------
  wire [7:0] ev = {3'b000, brk_ovf, 2'b00, stop_hit, brk_hit && !brk_ok_r}; // RQ7 RQ17
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_lo_r <= `LSUL_DIV_RST;
      div_hi_r <= 8'h00;
      frac_r <= 16'h0000;
      lcr_r <= `LSUL_LCR_RST;
      edge_r <= `LSUL_EDGE_RST;
      ctrla_r <= `LSUL_CTRLA_RST;
      cmp_r <= `LSUL_CMP_RST; // RQ19
      mask_r <= 8'h00;
      stat_r <= 8'h00;
      p2cfg_r <= 32'h00000000;
      p2dat_r <= 8'h00;
      p1cfg_r <= 8'h00;
      hvcfg_r <= 8'h00;
      sc_flag_r <= 1'b0;
      tx_byte_r <= 8'h00;
      tx_load_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_oe_r <= 1'b0;
      rx_fe_r <= 1'b0;
    end else begin
      tx_load_r <= 1'b0;
      stat_r <= ((wr && paddr == `LSUL_A_STAT) ? (stat_r & ~wst) : stat_r) | ev;
      if (sc_r && !hvcfg_r[`LSUL_HV_SCDIS]) sc_flag_r <= 1'b1; // RQ13 RQ15
      else if (wr && paddr == `LSUL_A_HVCFG && wst[`LSUL_HV_REEN]) sc_flag_r <= 1'b0; // RQ14
      if (udone) begin
        rx_byte_r <= udata; // RQ4
        rx_oe_r <= rx_full_r;
        rx_fe_r <= uferr;
        rx_full_r <= 1'b1;
      end else if (rd && paddr == `LSUL_A_RX) begin
        rx_full_r <= 1'b0;
      end
      if (rd && paddr == `LSUL_A_LSR) begin
        rx_oe_r <= udone ? rx_full_r : 1'b0;
        rx_fe_r <= udone ? uferr : 1'b0;
      end
      if (wr) begin
        case (paddr)
          `LSUL_A_TX: begin
            tx_byte_r <= wst;
            tx_load_r <= 1'b1; // RQ4
          end
          `LSUL_A_DIVLO: div_lo_r <= wst;
          `LSUL_A_DIVHI: div_hi_r <= wst;
          `LSUL_A_FRAC: frac_r <= pwdata[15:0];
          `LSUL_A_LCR: lcr_r <= wst;
          `LSUL_A_BRKT: cmp_r <= pwdata[11:0];
          `LSUL_A_CTRLA: ctrla_r <= pwdata[8:0];
          `LSUL_A_EDGE: edge_r <= wst;
          `LSUL_A_MASK: mask_r <= wst;
          `LSUL_A_P2DAT: p2dat_r <= wst;
          `LSUL_A_P2CFG: p2cfg_r <= pwdata;
          `LSUL_A_P1CFG: p1cfg_r <= wst;
          `LSUL_A_HVCFG: hvcfg_r <= wst;
          default: ;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // APB read path: one wait state in each access phase
  // ---------------------------------------------------------------
  reg [31:0] rmux;
  reg hit;
  always @* begin
    hit = 1'b1;
    rmux = 32'h00000000;
    case (paddr)
      `LSUL_A_TX: rmux = {24'h000000, tx_byte_r};
      `LSUL_A_RX: rmux = {24'h000000, rx_byte_r}; // RQ4
      `LSUL_A_DIVLO: rmux = {24'h000000, div_lo_r};
      `LSUL_A_DIVHI: rmux = {24'h000000, div_hi_r};
      `LSUL_A_FRAC: rmux = {16'h0000, frac_r};
      `LSUL_A_LCR: rmux = {24'h000000, lcr_r};
      `LSUL_A_LSR: rmux = {25'h0000000, !ubusy, !ubusy && !tx_load_r, 1'b0,
                           rx_fe_r, 1'b0, rx_oe_r, rx_full_r};
      `LSUL_A_SYNCT: rmux = {16'h0000, sync_t_r};
      `LSUL_A_BRKT: rmux = {20'h00000, brk_t_r};
      `LSUL_A_CTRLA: rmux = {23'h000000, ctrla_r};
      `LSUL_A_EDGE: rmux = {24'h000000, edge_r};
      `LSUL_A_STAT: rmux = {24'h000000, stat_r};
      `LSUL_A_MASK: rmux = {24'h000000, mask_r};
      `LSUL_A_P2DAT: rmux = {24'h000000, p2dat_r[7:5], lin_r, p2dat_r[3:0]}; // RQ11
      `LSUL_A_P2CFG: rmux = p2cfg_r;
      `LSUL_A_P1CFG: rmux = {24'h000000, p1cfg_r};
      `LSUL_A_HV_STATUS: rmux = {29'h00000000, sc_flag_r, 2'b00}; // RQ13
      `LSUL_A_HVCFG: rmux = {24'h000000, hvcfg_r};
      default: hit = 1'b0;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Ready is registered, so each access phase lasts exactly two cycles.
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      prdata <= (psel && !pwrite) ? rmux : 32'h00000000;
    end
  end
endmodule // lsul_link

// >>> src/lsul_uart.v
// Byte UART with fractional baud divider and ordinary 8N1-style framing.
`timescale 1ns/100ps
`include "lsul_consts.vh"
module lsul_uart (
  input wire pclk, // Core clock.
  input wire presetn, // Asynchronous reset, active low.
  input wire [15:0] div, // Integer baud divisor.
  input wire [15:0] frac, // Fractional divisor step.
  input wire [7:0] lcr, // Line control.
  input wire [7:0] tx_data, // Byte to send.
  input wire tx_load, // Pulse: start sending tx_data.
  input wire rxd, // Synchronised receive line.
  output reg txd, // Transmit line.
  output reg tx_busy, // Transmitter busy.
  output reg [7:0] rx_data, // Last received byte.
  output reg rx_done, // Pulse: byte received.
  output reg rx_ferr // Pulse with rx_done: stop bit was low.
);
  // ---------------------------------------------------------------
  // Oversampling tick from integer plus fractional divisor
  // ---------------------------------------------------------------
  reg [15:0] cnt_r;
  reg [16:0] facc_r;
  reg tick_r;
  wire [16:0] facc_sum = {1'b0, facc_r[15:0]} + {1'b0, frac};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      facc_r <= 17'h00000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (cnt_r + 16'h0001 >= div) begin
        // A carry out of the fraction drops this tick; the next one follows div + 1 clocks later.
        facc_r <= facc_sum;
        if (facc_r[16]) begin
          facc_r <= {1'b0, facc_r[15:0]};
          cnt_r <= 16'hFFFF;
        end else begin
          cnt_r <= 16'h0000;
          tick_r <= 1'b1;
        end
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
  wire [3:0] nbits = {2'b00, lcr[1:0]} + 4'h5;
  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  reg [3:0] tph_r;
  reg [3:0] tbit_r;
  reg [9:0] tsh_r;
  wire [3:0] tlast = nbits + (lcr[2] ? 4'h2 : 4'h1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      tx_busy <= 1'b0;
      tph_r <= 4'h0;
      tbit_r <= 4'h0;
      tsh_r <= 10'h3FF;
    end else if (tx_load && !tx_busy) begin
      tx_busy <= 1'b1;
      tsh_r <= {2'b11, tx_data};
      tph_r <= 4'h0;
      tbit_r <= 4'h0;
      txd <= 1'b0;
    end else if (tx_busy && tick_r) begin
      tph_r <= tph_r + 4'h1;
      if (tph_r == 4'hF) begin
        if (tbit_r == tlast) begin
          tx_busy <= 1'b0;
          txd <= 1'b1;
        end else begin
          txd <= (tbit_r < nbits) ? tsh_r[0] : 1'b1;
          tsh_r <= {1'b1, tsh_r[9:1]};
          tbit_r <= tbit_r + 4'h1;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Receiver: mid-bit sampling at 16x
  // ---------------------------------------------------------------
  reg rbusy_r;
  reg [3:0] rph_r;
  reg [3:0] rbit_r;
  reg [7:0] rsh_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbusy_r <= 1'b0;
      rph_r <= 4'h0;
      rbit_r <= 4'h0;
      rsh_r <= 8'h00;
      rx_data <= 8'h00;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
      if (tick_r) begin
        if (!rbusy_r) begin
          if (!rxd) begin
            rbusy_r <= 1'b1;
            rph_r <= 4'h0;
            rbit_r <= 4'h0;
          end
        end else begin
          rph_r <= rph_r + 4'h1;
          if (rph_r == 4'h7) begin
            if (rbit_r == 4'h0 && rxd) begin
              rbusy_r <= 1'b0;
            end else if (rbit_r == nbits + 4'h1) begin
              rbusy_r <= 1'b0;
              rx_data <= rsh_r >> (4'h8 - nbits);
              rx_done <= 1'b1;
              rx_ferr <= !rxd;
            end else begin
              if (rbit_r != 4'h0) begin
                rsh_r <= {rxd, rsh_r[7:1]};
              end
            end
            rbit_r <= rbit_r + 4'h1;
          end
        end
      end
    end
  end
endmodule // lsul_uart
